// ---- core/uxm_pkg.sv ----
package uxm_pkg;

  // Cycle figures at 200 MHz (period 5 ns)
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int PULSE_MIN_NS    = 200;
  localparam int PULSE_MAX_NS    = 500;
  // Aim 100 ns above the low end of the window so jitter of one cycle stays legal
  localparam int PULSE_TARGET_NS = 300;
  localparam int PULSE_MIN_CYC   = (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_MAX_CYC   = (PULSE_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int PULSE_CYC       = (PULSE_TARGET_NS * 1000) / CLK_PERIOD_PS;
  localparam int PCNT_W          = 8;

  localparam logic [1:0] DIR_RESET = 2'h0;

  typedef enum logic [2:0] {
    UXM_MODE_USB   = 3'h0,
    UXM_MODE_BUF   = 3'h1,
    UXM_MODE_AUDIO = 3'h2,
    UXM_MODE_UART  = 3'h3,
    UXM_MODE_OFF   = 3'h4
  } uxm_mode_t;

  typedef struct packed {
    logic uart_en;
    logic audio_en;
    logic transparent_enable;
    logic data_zero_select;
    logic [1:0] buffer_direction;
    logic tx_pulse_en;
    logic rx_pulse_en;
    logic audio_switch_en;
    logic audio_bias_en;
    logic mono_mic;
  } uxm_ctrl_t;

  // Per-line driver: output value, output enable, pull-down enable
  typedef struct packed {
    logic o;
    logic oe;
    logic pd;
  } uxm_line_t;

endpackage

// ---- core/uxm_mode_mux.sv ----
`timescale 1ns/1ps
`default_nettype none

module uxm_mode_mux (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Supplies and controls
  input  wire logic              core_supply_ok,
  input  wire logic              io_supply_ok,
  input  wire uxm_pkg::uxm_ctrl_t ctrl,
  input  wire logic              oe_pin,
  // Shared digital pins
  input  wire logic              shared_pin_a_in,
  output logic                   shared_pin_a_out,
  output logic                   shared_pin_a_oe,
  input  wire logic              shared_pin_b_in,
  output logic                   shared_pin_b_out,
  output logic                   shared_pin_b_oe,
  output logic                   diff_rx_out,
  output logic                   diff_rx_out_oe,
  // USB line side
  input  wire logic              dp_in,
  input  wire logic              dm_in,
  input  wire logic              diff_rx,
  output uxm_pkg::uxm_line_t     dp_line,
  output uxm_pkg::uxm_line_t     dm_line,
  // Status to analog blocks
  output uxm_pkg::uxm_mode_t     mode,
  output logic                   xcvr_enable,
  output logic                   carkit_int_det_en,
  output logic                   audio_switch_on,
  output logic                   audio_bias_on,
  output logic                   dp_carries_mic,
  output logic                   dm_carries_left
);

  uxm_pkg::uxm_mode_t mode_c;
  uxm_pkg::uxm_line_t dp_c;
  uxm_pkg::uxm_line_t dm_c;
  logic a_out_c, a_oe_c, b_out_c, b_oe_c, rcv_c, rcv_oe_c;
  logic rx_hold_reg, rx_hold_next;

  // Mode decode, supplies first, then UART since it overrides every other control bit
  always_comb begin
    if (!io_supply_ok || !core_supply_ok) begin
      mode_c = uxm_pkg::UXM_MODE_OFF;
    end else if (ctrl.uart_en) begin
      mode_c = uxm_pkg::UXM_MODE_UART;
    end else if (ctrl.audio_en && !ctrl.transparent_enable) begin
      mode_c = uxm_pkg::UXM_MODE_AUDIO;
    end else if (!ctrl.audio_en && ctrl.transparent_enable && ctrl.data_zero_select) begin
      mode_c = uxm_pkg::UXM_MODE_BUF;
    end else if (!ctrl.audio_en) begin
      mode_c = uxm_pkg::UXM_MODE_USB;
    end else begin
      // Audio with transparent set is undefined; park with drivers off
      mode_c = uxm_pkg::UXM_MODE_OFF;
    end
  end

  // Synchronisers and data-during-audio pulse logic
  logic [1:0] b_sync_reg, b_sync_next, p_sync_reg, p_sync_next;
  logic b_last_reg, b_last_next, p_last_reg, p_last_next;
  logic [uxm_pkg::PCNT_W-1:0] pcnt_reg, pcnt_next;
  logic toggle_reg, toggle_next;
  logic tx_act, rx_act;

  assign tx_act = (mode_c == uxm_pkg::UXM_MODE_AUDIO) && ctrl.tx_pulse_en;
  assign rx_act = (mode_c == uxm_pkg::UXM_MODE_AUDIO) && ctrl.rx_pulse_en;

  always_comb begin
    b_sync_next = {b_sync_reg[0], shared_pin_b_in};
    p_sync_next = {p_sync_reg[0], dp_in};
    b_last_next = b_sync_reg[1];
    p_last_next = p_sync_reg[1];
    pcnt_next   = pcnt_reg;
    toggle_next = toggle_reg;
    if (pcnt_reg != '0) begin
      pcnt_next = pcnt_reg - 1'b1;
    end
    // A change during a running pulse restarts it; pulses cannot overlap
    if (tx_act && (b_sync_reg[1] != b_last_reg)) begin
      pcnt_next = uxm_pkg::PCNT_W'(uxm_pkg::PULSE_CYC);
    end
    if (!tx_act) begin
      pcnt_next = '0;
    end
    // Rising edge of plus line ends a low pulse
    if (rx_act && p_sync_reg[1] && !p_last_reg) begin
      toggle_next = ~toggle_reg;
    end
    if (!rx_act) begin
      toggle_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      b_sync_reg <= 2'h0;
      p_sync_reg <= 2'h3;
      b_last_reg <= 1'b0;
      p_last_reg <= 1'b1;
      pcnt_reg   <= '0;
      toggle_reg <= 1'b0;
    end else begin
      b_sync_reg <= b_sync_next;
      p_sync_reg <= p_sync_next;
      b_last_reg <= b_last_next;
      p_last_reg <= p_last_next;
      pcnt_reg   <= pcnt_next;
      toggle_reg <= toggle_next;
    end
  end

  // Pin routing
  always_comb begin
    dp_c     = '0;
    dm_c     = '0;
    a_out_c  = 1'b0;
    a_oe_c   = 1'b0;
    b_out_c  = 1'b0;
    b_oe_c   = 1'b0;
    rcv_c    = 1'b0;
    rcv_oe_c = 1'b0;
    rx_hold_next = rx_hold_reg;
    case (mode_c)
      uxm_pkg::UXM_MODE_USB: begin
        // Differential receiver holds its last value on SE0 or SE1
        if (dp_in != dm_in) begin
          rx_hold_next = diff_rx;
        end
        rcv_c    = rx_hold_next;
        rcv_oe_c = 1'b1;
        if (!ctrl.data_zero_select) begin
          if (!oe_pin) begin
            dp_c = '{o: shared_pin_a_in, oe: 1'b1, pd: 1'b0};
            dm_c = '{o: shared_pin_b_in, oe: 1'b1, pd: 1'b0};
          end else begin
            a_out_c = dp_in;
            b_out_c = dm_in;
            a_oe_c  = 1'b1;
            b_oe_c  = 1'b1;
          end
        end else begin
          if (!oe_pin) begin
            // Forced zero overrides data
            dp_c = '{o: shared_pin_a_in && !shared_pin_b_in, oe: 1'b1, pd: 1'b0};
            dm_c = '{o: !shared_pin_a_in && !shared_pin_b_in, oe: 1'b1, pd: 1'b0};
          end else begin
            a_out_c = rx_hold_next;
            b_out_c = !dp_in && !dm_in;
            a_oe_c  = 1'b1;
            b_oe_c  = 1'b1;
          end
        end
      end
      uxm_pkg::UXM_MODE_UART: begin
        dm_c    = '{o: shared_pin_b_in, oe: 1'b1, pd: 1'b0};
        a_out_c = dp_in;
        a_oe_c  = 1'b1;
      end
      uxm_pkg::UXM_MODE_BUF: begin
        if (!ctrl.buffer_direction[1]) begin
          dp_c = '{o: shared_pin_a_in, oe: 1'b1, pd: 1'b0};
        end else begin
          a_out_c = dp_in;
          a_oe_c  = 1'b1;
        end
        if (!ctrl.buffer_direction[0]) begin
          dm_c = '{o: shared_pin_b_in, oe: 1'b1, pd: 1'b0};
        end else begin
          b_out_c = dm_in;
          b_oe_c  = 1'b1;
        end
      end
      uxm_pkg::UXM_MODE_AUDIO: begin
        // Data-line drivers stay off except for transmit pulses
        if (pcnt_reg != '0) begin
          dm_c = '{o: 1'b1, oe: 1'b1, pd: 1'b0};
        end
        if (rx_act) begin
          a_out_c = toggle_reg;
          a_oe_c  = 1'b1;
        end
      end
      default: begin
        if (core_supply_ok && !io_supply_ok) begin
          dp_c.pd = 1'b1;
          dm_c.pd = 1'b1;
        end else if (!core_supply_ok && io_supply_ok) begin
          rcv_oe_c = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      shared_pin_a_out  <= 1'b0;
      shared_pin_a_oe   <= 1'b0;
      shared_pin_b_out  <= 1'b0;
      shared_pin_b_oe   <= 1'b0;
      diff_rx_out       <= 1'b0;
      diff_rx_out_oe    <= 1'b0;
      dp_line           <= '0;
      dm_line           <= '0;
      mode              <= uxm_pkg::UXM_MODE_OFF;
      xcvr_enable       <= 1'b0;
      carkit_int_det_en <= 1'b0;
      audio_switch_on   <= 1'b0;
      audio_bias_on     <= 1'b0;
      dp_carries_mic    <= 1'b0;
      dm_carries_left   <= 1'b0;
      rx_hold_reg       <= 1'b0;
    end else begin
      shared_pin_a_out  <= a_out_c;
      shared_pin_a_oe   <= a_oe_c;
      shared_pin_b_out  <= b_out_c;
      shared_pin_b_oe   <= b_oe_c;
      diff_rx_out       <= rcv_c;
      diff_rx_out_oe    <= rcv_oe_c;
      dp_line           <= dp_c;
      dm_line           <= dm_c;
      mode              <= mode_c;
      xcvr_enable       <= (mode_c == uxm_pkg::UXM_MODE_USB);
      carkit_int_det_en <= (mode_c == uxm_pkg::UXM_MODE_AUDIO);
      audio_switch_on   <= (mode_c == uxm_pkg::UXM_MODE_AUDIO) && ctrl.audio_switch_en;
      audio_bias_on     <= (mode_c == uxm_pkg::UXM_MODE_AUDIO) && ctrl.audio_bias_en;
      dp_carries_mic    <= (mode_c == uxm_pkg::UXM_MODE_AUDIO) && ctrl.mono_mic;
      dm_carries_left   <= (mode_c == uxm_pkg::UXM_MODE_AUDIO);
      rx_hold_reg       <= rx_hold_next;
    end
  end

  // Checks
  int unsigned hi_run;
  always_ff @(posedge clk) begin
    if (reset || !(dm_line.o && dm_line.oe && mode == uxm_pkg::UXM_MODE_AUDIO)) begin
      hi_run <= 0;
    end else begin
      hi_run <= hi_run + 1;
    end
  end

  a_pulse_width_max: assert property (@(posedge clk) disable iff (reset)
    hi_run <= uxm_pkg::PULSE_MAX_CYC) else $error("transmit pulse too long");
  a_pulse_width_min: assert property (@(posedge clk) disable iff (reset)
    $fell(dm_line.o) && mode == uxm_pkg::UXM_MODE_AUDIO && $past(mode) == mode
      |-> $past(hi_run) + 1 >= uxm_pkg::PULSE_MIN_CYC) else $error("transmit pulse too short");
  a_uart_wins_mode: assert property (@(posedge clk) disable iff (reset)
    ctrl.uart_en && core_supply_ok && io_supply_ok |=> mode == uxm_pkg::UXM_MODE_UART)
    else $error("uart enable not obeyed");
  a_xcvr_only_usb: assert property (@(posedge clk) disable iff (reset)
    xcvr_enable |-> !$past(ctrl.uart_en) && !$past(ctrl.audio_en) && $past(io_supply_ok))
    else $error("transceiver on outside usb mode");
  a_io_off_float: assert property (@(posedge clk) disable iff (reset)
    !io_supply_ok && core_supply_ok |=> dp_line.pd && dm_line.pd && !dp_line.oe
      && !dm_line.oe && !shared_pin_a_oe) else $error("disable mode pins wrong");
  a_isolate_rcv_low: assert property (@(posedge clk) disable iff (reset)
    !core_supply_ok && io_supply_ok |=> diff_rx_out_oe && !diff_rx_out && !shared_pin_b_oe)
    else $error("isolate mode pins wrong");
  a_uart_passes_tx: assert property (@(posedge clk) disable iff (reset)
    mode == uxm_pkg::UXM_MODE_UART |-> dm_line.oe && !dp_line.oe && shared_pin_a_oe)
    else $error("uart routing wrong");
  a_no_tx_pulse_off: assert property (@(posedge clk) disable iff (reset)
    mode == uxm_pkg::UXM_MODE_AUDIO && !$past(ctrl.tx_pulse_en, 2) && !$past(ctrl.tx_pulse_en)
      |-> !dm_line.oe) else $error("pulse while disabled");
  a_rx_toggle_pin: assert property (@(posedge clk) disable iff (reset)
    rx_act && $rose(p_sync_reg[1]) && $stable(rx_act) |=> ##1 shared_pin_a_out != $past(shared_pin_a_out))
    else $error("receive pulse did not toggle pin a");

  c_tx_pulse: cover property (@(posedge clk) disable iff (reset) $rose(dm_line.o));
  c_uart_mode: cover property (@(posedge clk) disable iff (reset) mode == uxm_pkg::UXM_MODE_UART);
  c_buf_mode: cover property (@(posedge clk) disable iff (reset) mode == uxm_pkg::UXM_MODE_BUF);
  c_rx_toggle: cover property (@(posedge clk) disable iff (reset) rx_act && $changed(toggle_reg));

endmodule // uxm_mode_mux

`default_nettype wire

// ---- sim/uxm_cable_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module uxm_cable_model (
  // Device line drivers
  input  wire uxm_pkg::uxm_line_t dp_line,
  input  wire uxm_pkg::uxm_line_t dm_line,
  // Far end levels
  input  wire logic               far_dp,
  input  wire logic               far_dm,
  // Line receivers
  output logic                    dp_in,
  output logic                    dm_in,
  output logic                    diff_rx
);
  // Device driver wins; the far end always drives, so a pull-down never decides the level
  assign dp_in = dp_line.oe ? dp_line.o : far_dp;
  assign dm_in = dm_line.oe ? dm_line.o : far_dm;
  // Differential receiver keeps its last value while both lines are equal
  initial diff_rx = 1'b0;
  always @(dp_in or dm_in) if (dp_in !== dm_in) diff_rx = dp_in;
endmodule // uxm_cable_model
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, reset = 1'b1, core_ok = 1'b1, io_ok = 1'b1, oe_pin = 1'b0;
  logic a_in = 1'b0, b_in = 1'b0, far_dp = 1'b1, far_dm = 1'b0, p;
  logic a_out, a_oe, b_out, b_oe, rx_out, rx_oe, dp_in, dm_in, diff_rx;
  logic xcvr, cki, sw, bias, mic, left;
  uxm_pkg::uxm_ctrl_t ctrl = '0;
  uxm_pkg::uxm_line_t dp_line, dm_line;
  uxm_pkg::uxm_mode_t mode;
  int err_count = 0, n_tests = 0, k;
  uxm_mode_mux dut_u (.clk(clk), .reset(reset), .core_supply_ok(core_ok),
    .io_supply_ok(io_ok), .ctrl(ctrl), .oe_pin(oe_pin), .shared_pin_a_in(a_in),
    .shared_pin_a_out(a_out), .shared_pin_a_oe(a_oe), .shared_pin_b_in(b_in),
    .shared_pin_b_out(b_out), .shared_pin_b_oe(b_oe), .diff_rx_out(rx_out),
    .diff_rx_out_oe(rx_oe), .dp_in(dp_in), .dm_in(dm_in), .diff_rx(diff_rx),
    .dp_line(dp_line), .dm_line(dm_line), .mode(mode), .xcvr_enable(xcvr),
    .carkit_int_det_en(cki), .audio_switch_on(sw), .audio_bias_on(bias),
    .dp_carries_mic(mic), .dm_carries_left(left));
  uxm_cable_model cab_u (.dp_line(dp_line), .dm_line(dm_line), .far_dp(far_dp),
    .far_dm(far_dm), .dp_in(dp_in), .dm_in(dm_in), .diff_rx(diff_rx));
  initial forever #2.5 clk = ~clk;
  task automatic chk(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chm(uxm_pkg::uxm_mode_t e);
    n_tests++;
    if (mode !== e) begin
      err_count++;
      $display("FAIL mode exp %0d got %0d", e, mode);
    end
  endtask
  // Controller side of the pins and far end of the cable, then settle
  task automatic set(logic [10:0] c, logic o, logic a, logic b, logic fp, logic fm);
    @(posedge clk);
    ctrl <= uxm_pkg::uxm_ctrl_t'(c);
    oe_pin <= o;
    a_in <= a;
    b_in <= b;
    far_dp <= fp;
    far_dm <= fm;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic cnt_hi(int n);
    k = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (dm_line.o === 1'b1) k++;
    end
  endtask
  // Low pulse of four cycles on the plus line, then time for the synchroniser
  task automatic rxp();
    @(posedge clk);
    far_dp <= 1'b0;
    repeat (4) @(posedge clk);
    far_dp <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    #1;
    chm(uxm_pkg::UXM_MODE_OFF);
    set(11'h000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chm(uxm_pkg::UXM_MODE_USB);
    chk("xcvr", 1'b1, xcvr);
    chk("dp_o", 1'b1, dp_line.o);
    chk("dm_o", 1'b0, dm_line.o);
    chk("dm_oe", 1'b1, dm_line.oe);
    set(11'h000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    chk("a_out", 1'b0, a_out);
    chk("b_out", 1'b1, b_out);
    chk("b_oe", 1'b1, b_oe);
    chk("rx_out", 1'b0, rx_out);
    set(11'h080, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("dp_o", 1'b0, dp_line.o);
    chk("dm_o", 1'b1, dm_line.o);
    set(11'h080, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    chk("force_single_ended_zero", 1'b0, dp_line.o | dm_line.o);
    set(11'h080, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("a_out", 1'b1, a_out);
    chk("b_out", 1'b0, b_out);
    chk("rx_out", 1'b1, rx_out);
    set(11'h080, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("seen_single_ended_zero", 1'b1, b_out);
    chk("se0_hold", 1'b1, a_out);
    chk("se0_rcv", 1'b1, rx_out);
    set(11'h100, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    chm(uxm_pkg::UXM_MODE_USB);
    chk("xcvr", 1'b1, xcvr);
    for (int i = 0; i < 2; i++) begin
      set(11'h7FF, 1'b0, 1'b0, i[0], i[0], 1'b0);
      chm(uxm_pkg::UXM_MODE_UART);
      chk("xcvr", 1'b0, xcvr);
      chk("dm_o", i[0], dm_line.o);
      chk("a_out", i[0], a_out);
    end
    set(11'h207, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    chm(uxm_pkg::UXM_MODE_AUDIO);
    chk("dp_oe", 1'b0, dp_line.oe);
    chk("cki", 1'b1, cki);
    chk("sw", 1'b1, sw);
    chk("bias", 1'b1, bias);
    chk("mic", 1'b1, mic);
    chk("left", 1'b1, left);
    set(11'h282, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    chm(uxm_pkg::UXM_MODE_AUDIO);
    chk("mic", 1'b0, mic);
    chk("sw", 1'b0, sw);
    // Audio with transparent set is not a documented mode: drivers park
    set(11'h300, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chm(uxm_pkg::UXM_MODE_OFF);
    chk("park_xcvr", 1'b0, xcvr);
    chk("park_oe", 1'b0, dp_line.oe | dm_line.oe | a_oe | b_oe);
    for (int d = 0; d < 4; d++) begin
      set({4'h3, 2'(d), 5'h00}, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      chm(uxm_pkg::UXM_MODE_BUF);
      chk("a_oe", d[1], a_oe);
      chk("b_oe", d[0], b_oe);
      chk("buf_a", ~d[1], d[1] ? a_out : dp_line.o);
      chk("buf_b", d[0], d[0] ? b_out : dm_line.o);
    end
    // Each change of pin b, rising and falling, makes exactly one pulse
    set(11'h210, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      b_in <= ~b_in;
      cnt_hi(120);
      chk("pw_win", 1'b1, k >= uxm_pkg::PULSE_MIN_CYC && k <= uxm_pkg::PULSE_MAX_CYC);
      chk("pw", 1'b1, k == uxm_pkg::PULSE_CYC);
    end
    set(11'h200, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    b_in <= 1'b1;
    cnt_hi(120);
    chk("no_pulse", 1'b1, k == 0);
    set(11'h208, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    p = a_out;
    rxp();
    chk("rx_tog", ~p, a_out);
    set(11'h200, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    rxp();
    chk("rx_off", 1'b0, a_out);
    chk("rx_off_oe", 1'b0, a_oe);
    @(posedge clk);
    io_ok <= 1'b0;
    set(11'h000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("dp_pd", 1'b1, dp_line.pd);
    chk("dm_pd", 1'b1, dm_line.pd);
    chk("dp_oe", 1'b0, dp_line.oe | dm_line.oe);
    chk("pin_oe", 1'b0, a_oe | b_oe | rx_oe);
    @(posedge clk);
    io_ok <= 1'b1;
    core_ok <= 1'b0;
    set(11'h000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("rx_oe", 1'b1, rx_oe);
    chk("rx_out", 1'b0, rx_out);
    chk("pin_oe", 1'b0, a_oe | b_oe | dp_line.oe | dm_line.oe);
    chk("dp_pd", 1'b0, dp_line.pd);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
